// [shared/tpc_pkg.sv]
package tpc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [13:0] IDX_CNT_H = 14'h0f00;
  localparam logic [13:0] IDX_CNT_L = 14'h0f01;
  localparam logic [13:0] IDX_RLD_H = 14'h0f02;
  localparam logic [13:0] IDX_RLD_L = 14'h0f03;
  localparam logic [13:0] IDX_CMP_H = 14'h0f04;
  localparam logic [13:0] IDX_CMP_L = 14'h0f05;
  localparam logic [13:0] IDX_CTL0 = 14'h0f06;
  localparam logic [13:0] IDX_CTL1 = 14'h0f07;
  localparam int ADDR_W = 16;
  localparam int IDX_LSB = 2;

  // ==========================================================
  // Reset values and count restart value
  // ==========================================================
  localparam logic [15:0] CNT_RST = 16'h0001;
  localparam logic [15:0] RLD_RST = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] CNT_START = 16'h0001;

  // ==========================================================
  // Control field layouts
  // ==========================================================
  typedef struct packed {
    logic enable;         // [7]
    logic output_polarity_bit; // [6]
    logic [2:0] clock_divide_select; // [5:3]
    logic [2:0] mode_lo;  // [2:0]
  } tpc_ctl1_t;

  typedef struct packed {
    logic mode_hi;        // [7]
    logic [2:0] rsv_hi;   // [6:4]
    logic [2:0] deadband_delay_select; // [3:1]
    logic rsv_lo;         // [0]
  } tpc_ctl0_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } tpc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tpc_apb_rsp_t;

  // ==========================================================
  // Timer modes, {mode_hi, mode_lo}
  // ==========================================================
  localparam logic [3:0] MODE_CONT = 4'h1;
  localparam logic [3:0] MODE_PWM = 4'h3;
  localparam logic [3:0] MODE_CAPT = 4'h4;
  localparam logic [3:0] MODE_CAPCMP = 4'h7;
  localparam logic [3:0] MODE_PWM_DUAL = 4'h8;
  localparam logic [3:0] MODE_CAP_RST = 4'h9;

endpackage

// [core/tpc_prescaler.sv]
`timescale 1ns/1ps
module tpc_prescaler #(
  parameter int SEL_W = 3
) (
  input wire logic ref_clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic run_i, // Timer enabled
  input wire logic [SEL_W-1:0] sel_i, // Divide by 2**sel
  output logic tick_o // One-cycle count enable
);

  localparam int CNT_W = (1 << SEL_W) - 1;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] mask;

  always_comb begin
    mask = CNT_W'((1 << sel_i) - 1);
  end

  // ==========================================================
  // Divider, cleared whenever the timer stops
  // ==========================================================
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= '0;
    end else if (!run_i) begin
      cnt_reg <= '0; // [R13]
    end else if ((cnt_reg & mask) == mask) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // Tick is combinational from the divider; top registers all effects
  assign tick_o = run_i && ((cnt_reg & mask) == mask); // [R12]

endmodule

// [core/tpc_timer_out.sv]
`timescale 1ns/1ps
// Operation
// R1: Match 16-bit compare value against timer count
// R2: Capture modes store count in compare bytes
// R3: Dual PWM, polarity 0, disabled: low/high
// R4: Dual PWM pol 0: output high match, low reload
// R5: Dual PWM pol 0: complement low match, high reload
// R6: Dual PWM, polarity 1, disabled: high/low
// R7: Deadband delays rising edge of both outputs
// R8: Capture restart edge set by polarity
// R9: Other modes: idle at polarity, toggle on reload
// R10: Enabled pin function drives polarity level
// R11: Polarity change while running takes no effect
// R12: Prescaler divides by two to select power
// R13: Prescaler cleared while timer disabled
// R14: Dual PWM pol 1 inverts pol 0 behaviour
module tpc_timer_out #(
  parameter int DB_W = 3
) (
  input wire logic ref_clk_i, // 10 MHz system clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [tpc_pkg::ADDR_W-1:0] paddr_i, // APB address
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error, unmapped
  input wire logic timer_in_i, // Timer input pin level
  input wire logic alt_fn_en_i, // Pin alternate function on
  output logic timer_output_pin_o, // Timer output
  output logic timer_output_comp_o, // Timer output complement
  output logic pin_out_o, // Pad data
  output logic pin_oe_n_o // Pad enable, low drives
);

  // ==========================================================
  // Registers and decode
  // ==========================================================
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [15:0] compare_reg;
  tpc_pkg::tpc_ctl0_t ctl0_reg;
  tpc_pkg::tpc_ctl1_t ctl1_reg;
  logic pol_run_reg;
  logic in_prev_reg;
  logic out_raw_reg;
  logic comp_raw_reg;
  logic [13:0] idx;
  logic aligned;
  logic mapped;
  logic access;
  logic wr;
  logic [7:0] wbyte;
  logic [3:0] mode;
  logic run;
  logic tick;
  logic reload_ev;
  logic match_ev;
  logic edge_ev;
  logic capture_ev;
  logic restart_ev;
  logic [7:0] rd_byte;

  assign idx = paddr_i[tpc_pkg::ADDR_W-1:tpc_pkg::IDX_LSB];
  assign aligned = (paddr_i[tpc_pkg::IDX_LSB-1:0] == 2'h0);
  assign wbyte = pwdata_i[7:0];
  assign mode = {ctl0_reg.mode_hi, ctl1_reg.mode_lo};
  assign run = ctl1_reg.enable;

  always_comb begin
    mapped = aligned;
    rd_byte = 8'h00;
    case (idx)
      tpc_pkg::IDX_CNT_H: rd_byte = count_reg[15:8];
      tpc_pkg::IDX_CNT_L: rd_byte = count_reg[7:0];
      tpc_pkg::IDX_RLD_H: rd_byte = reload_reg[15:8];
      tpc_pkg::IDX_RLD_L: rd_byte = reload_reg[7:0];
      tpc_pkg::IDX_CMP_H: rd_byte = compare_reg[15:8];
      tpc_pkg::IDX_CMP_L: rd_byte = compare_reg[7:0];
      tpc_pkg::IDX_CTL0: rd_byte = ctl0_reg;
      tpc_pkg::IDX_CTL1: rd_byte = ctl1_reg;
      default: mapped = 1'b0;
    endcase
  end

  // Transfer completes in the first access cycle
  assign access = psel_i && penable_i && pready_o;
  assign wr = access && pwrite_i && mapped;

  // ==========================================================
  // APB answer
  // ==========================================================
  // Ready rises one cycle after setup, so no wait states
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      pready_o <= 1'b1;
      pslverr_o <= !mapped;
      prdata_o <= pwrite_i ? 32'h0000_0000 : {24'h000000, rd_byte};
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl0_reg <= tpc_pkg::CTL_RST;
      ctl1_reg <= tpc_pkg::CTL_RST;
    end else if (wr) begin
      if (idx == tpc_pkg::IDX_CTL0) begin
        ctl0_reg <= wbyte;
      end
      if (idx == tpc_pkg::IDX_CTL1) begin
        ctl1_reg <= wbyte;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reload_reg <= tpc_pkg::RLD_RST;
    end else if (wr) begin
      if (idx == tpc_pkg::IDX_RLD_H) begin
        reload_reg[15:8] <= wbyte;
      end
      if (idx == tpc_pkg::IDX_RLD_L) begin
        reload_reg[7:0] <= wbyte;
      end
    end
  end

  // Polarity is sampled only while stopped
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pol_run_reg <= 1'b0;
    end else if (!run) begin
      pol_run_reg <= ctl1_reg.output_polarity_bit; // [R11]
    end
  end

  // ==========================================================
  // Counting and events
  // ==========================================================
  tpc_prescaler #(
    .SEL_W(3)
  ) u_presc (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .run_i(run),
    .sel_i(ctl1_reg.clock_divide_select),
    .tick_o(tick)
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_prev_reg <= 1'b0;
    end else begin
      in_prev_reg <= timer_in_i;
    end
  end

  // Edge choice follows the running polarity
  assign edge_ev = pol_run_reg ? (in_prev_reg && !timer_in_i)
                               : (!in_prev_reg && timer_in_i); // [R8]
  assign capture_ev = run && edge_ev &&
    (mode == tpc_pkg::MODE_CAPT || mode == tpc_pkg::MODE_CAPCMP ||
     mode == tpc_pkg::MODE_CAP_RST);
  assign restart_ev = capture_ev && (mode != tpc_pkg::MODE_CAPT);
  assign reload_ev = tick && (count_reg == reload_reg);
  assign match_ev = tick && (count_reg == compare_reg); // [R1]

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= tpc_pkg::CNT_RST;
    end else if (restart_ev) begin
      count_reg <= tpc_pkg::CNT_START;
    end else if (wr && idx == tpc_pkg::IDX_CNT_H) begin
      count_reg[15:8] <= wbyte;
    end else if (wr && idx == tpc_pkg::IDX_CNT_L) begin
      count_reg[7:0] <= wbyte;
    end else if (reload_ev) begin
      count_reg <= tpc_pkg::CNT_START;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Capture beats a software write in the same cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      compare_reg <= tpc_pkg::CMP_RST;
    end else if (capture_ev) begin
      compare_reg <= count_reg; // [R2]
    end else if (wr && idx == tpc_pkg::IDX_CMP_H) begin
      compare_reg[15:8] <= wbyte;
    end else if (wr && idx == tpc_pkg::IDX_CMP_L) begin
      compare_reg[7:0] <= wbyte;
    end
  end

  // ==========================================================
  // Output waveform before deadband
  // ==========================================================
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_raw_reg <= 1'b0;
      comp_raw_reg <= 1'b1;
    end else if (!run) begin
      // Stopped level follows the live bit so the pad sees it
      out_raw_reg <= ctl1_reg.output_polarity_bit; // [R3] [R6] [R9]
      comp_raw_reg <= !ctl1_reg.output_polarity_bit; // [R3] [R6]
    end else if (mode == tpc_pkg::MODE_PWM_DUAL) begin
      if (reload_ev) begin
        out_raw_reg <= pol_run_reg; // [R4] [R14]
        comp_raw_reg <= !pol_run_reg; // [R5] [R14]
      end else if (match_ev) begin
        out_raw_reg <= !pol_run_reg; // [R4] [R14]
        comp_raw_reg <= pol_run_reg; // [R5] [R14]
      end
    end else if (mode == tpc_pkg::MODE_PWM) begin
      if (reload_ev) begin
        out_raw_reg <= pol_run_reg;
      end else if (match_ev) begin
        out_raw_reg <= !pol_run_reg;
      end
    end else if (reload_ev) begin
      out_raw_reg <= !out_raw_reg; // [R9]
    end
  end

  // ==========================================================
  // Deadband on rising edges of both outputs, in dual PWM while running only
  // ==========================================================
  logic [1:0] raw_vec;
  logic [1:0] db_out;
  logic db_on;

  assign raw_vec = {comp_raw_reg, out_raw_reg};
  assign db_on = run && (mode == tpc_pkg::MODE_PWM_DUAL);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_db
      logic [DB_W-1:0] wait_reg;
      logic q_reg;
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          wait_reg <= '0;
          q_reg <= (g == 1);
        end else if (!raw_vec[g]) begin
          wait_reg <= '0;
          q_reg <= 1'b0;
        end else if (!db_on ||
                     wait_reg >= ctl0_reg.deadband_delay_select) begin
          q_reg <= 1'b1; // [R7]
        end else begin
          wait_reg <= wait_reg + DB_W'(1); // [R7]
        end
      end
      assign db_out[g] = q_reg;
    end
  endgenerate

  // ==========================================================
  // Pins
  // ==========================================================
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_output_pin_o <= 1'b0;
      timer_output_comp_o <= 1'b1;
      pin_out_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      timer_output_pin_o <= db_out[0];
      timer_output_comp_o <= db_out[1];
      pin_out_o <= db_out[0];
      pin_oe_n_o <= !alt_fn_en_i; // [R10]
    end
  end

endmodule

// [sim/tpc_pin_partner.sv]
`timescale 1ns/1ps
module tpc_pin_partner (
  input wire logic level_i, // Wanted input level
  input wire logic pin_out_i, // Pad data
  input wire logic pin_oe_n_i, // Pad enable
  output logic timer_in_o, // Timer input pin
  output logic pad_o // Pad level seen
);
  // Source is launched by the bench at the edge
  assign timer_in_o = level_i;
  // Pull-up shows whenever the block lets go of the pad
  assign pad_o = pin_oe_n_i ? 1'b1 : pin_out_i;
endmodule

// [sim/tpc_timer_out_checker.sv]
`timescale 1ns/1ps
module tpc_timer_out_checker (
  input wire logic ref_clk_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic [tpc_pkg::ADDR_W-1:0] paddr_i, // Address
  input wire logic psel_i, // Select
  input wire logic penable_i, // Enable
  input wire logic pwrite_i, // Write
  input wire logic [31:0] pwdata_i, // Write data
  input wire logic [31:0] prdata_o, // Read data
  input wire logic pready_o, // Ready
  input wire logic pslverr_o, // Error
  input wire logic alt_fn_en_i, // Pin function
  input wire logic timer_output_pin_o, // Output
  input wire logic timer_output_comp_o, // Complement
  input wire logic pin_oe_n_o // Pad enable
);
  // ==========================================================
  // Control shadow
  logic [7:0] ctl0_reg;
  logic [7:0] ctl1_reg;
  logic [2:0] age_reg;
  logic wr_ok;
  logic dual;
  logic calm;
  assign wr_ok = psel_i & penable_i & pready_o & pwrite_i & !pslverr_o;
  assign dual = {ctl0_reg[7], ctl1_reg[2:0]} == tpc_pkg::MODE_PWM_DUAL;
  assign calm = age_reg == 3'h4 && !ctl1_reg[7];
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl0_reg <= 8'h00;
      ctl1_reg <= 8'h00;
    end else if (wr_ok && paddr_i[15:2] == tpc_pkg::IDX_CTL0) begin
      ctl0_reg <= pwdata_i[7:0];
    end else if (wr_ok && paddr_i[15:2] == tpc_pkg::IDX_CTL1) begin
      ctl1_reg <= pwdata_i[7:0];
    end
  end
  // Pins lag a write by three clocks, so judge only after four
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      age_reg <= 3'h0;
    end else if (wr_ok) begin
      age_reg <= 3'h0;
    end else if (age_reg != 3'h4) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_setup_answer: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_once: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_refusal_zero: assert property (pslverr_o |-> pready_o && !prdata_o)
    else $error("bad refusal");
  a_dual_apart: assert property (
    dual && ctl1_reg[7] && age_reg == 3'h4
      |-> !(timer_output_pin_o && timer_output_comp_o))
    else $error("both dual outputs high");
  a_dual_rest_low: assert property (
    calm && dual && !ctl1_reg[6]
      |-> !timer_output_pin_o && timer_output_comp_o)
    else $error("dual idle low wrong");
  a_dual_rest_high: assert property (
    calm && dual && ctl1_reg[6]
      |-> timer_output_pin_o && !timer_output_comp_o)
    else $error("dual idle high wrong");
  a_plain_rest: assert property (
    calm && !dual |-> timer_output_pin_o == ctl1_reg[6])
    else $error("idle output wrong");
  a_pad_enable: assert property (
    $past(arst_n_i) |-> pin_oe_n_o == !$past(alt_fn_en_i))
    else $error("pad enable wrong");
  c_dual_run: cover property (dual && ctl1_reg[7] && timer_output_pin_o);
  c_refused: cover property (pslverr_o);
  c_pad_on: cover property (calm && !pin_oe_n_o);
endmodule

bind tpc_timer_out tpc_timer_out_checker i_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .paddr_i(paddr_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .alt_fn_en_i(alt_fn_en_i),
  .timer_output_pin_o(timer_output_pin_o),
  .timer_output_comp_o(timer_output_comp_o), .pin_oe_n_o(pin_oe_n_o)
);

// [sim/tpc_timer_out_tb.sv]
`timescale 1ns/1ps
module tpc_timer_out_tb;
  logic ref_clk_i;
  logic arst_n_i = 1'b0;
  logic level = 1'b1;
  logic alt_fn = 1'b0;
  logic tin;
  logic pad;
  logic out;
  logic comp;
  logic pout;
  logic poe_n;
  logic [31:0] q;
  logic e;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  tpc_pkg::tpc_apb_req_t req = '0;
  tpc_pkg::tpc_apb_rsp_t rsp;

  tpc_timer_out i_dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .paddr_i(req.paddr),
    .psel_i(req.psel), .penable_i(req.penable), .pwrite_i(req.pwrite),
    .pwdata_i(req.pwdata), .prdata_o(rsp.prdata), .pready_o(rsp.pready),
    .pslverr_o(rsp.pslverr), .timer_in_i(tin), .alt_fn_en_i(alt_fn),
    .timer_output_pin_o(out), .timer_output_comp_o(comp),
    .pin_out_o(pout), .pin_oe_n_o(poe_n)
  );
  tpc_pin_partner i_pins (
    .level_i(level), .pin_out_i(pout), .pin_oe_n_i(poe_n),
    .timer_in_o(tin), .pad_o(pad)
  );

  // ==========================================================
  // Clock, watchdog, shared tasks
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] x, y);
    check_count++;
    if (y !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", w, x, y);
    end
  endtask
  // Request stands until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [13:0] a,
      input logic [7:0] d);
    @(posedge ref_clk_i);
    req.paddr <= {a, 2'b00};
    req.pwrite <= w;
    req.pwdata <= {24'h0, d};
    req.psel <= 1'b1;
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Window of ten clocks equals one dual period
  task automatic hi(output int ho, output int hc);
    ho = 0;
    hc = 0;
    wait_clk(20);
    repeat (10) begin
      @(negedge ref_clk_i);
      ho += 32'(out);
      hc += 32'(comp);
    end
  endtask
  task automatic lag(output int t);
    t = 0;
    while (out === 1'b0 && t < 100) begin
      @(negedge ref_clk_i);
      t++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    chk("reset pins", 32'h1, {30'h0, out, comp});
    apb(1'b0, tpc_pkg::IDX_CMP_L, 8'h00);
    chk("cmp low reset", 32'h0, q);
    apb(1'b1, tpc_pkg::IDX_CMP_H, 8'ha5);
    apb(1'b0, tpc_pkg::IDX_CMP_H, 8'h00);
    chk("cmp high rw", 32'ha5, q);
    apb(1'b0, 14'h0f10, 8'h00);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("t_regs done");
  endtask
  task automatic t_presc();
    int p;
    int t1;
    apb(1'b1, tpc_pkg::IDX_RLD_H, 8'h00);
    apb(1'b1, tpc_pkg::IDX_RLD_L, 8'h02);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, tpc_pkg::IDX_CTL1, 8'h81 | 8'(s << 3));
      lag(p);
      lag(p);
      lag(p);
      p = 0;
      while (out === 1'b1 && p < 600) begin
        @(negedge ref_clk_i);
        p++;
      end
      chk("period", 32'(2 << s), 32'(p));
      apb(1'b1, tpc_pkg::IDX_CTL1, 8'h19);
      apb(1'b1, tpc_pkg::IDX_CNT_L, 8'h01);
    end
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h99);
    lag(t1);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h19);
    apb(1'b1, tpc_pkg::IDX_CNT_L, 8'h01);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h99);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h19);
    apb(1'b1, tpc_pkg::IDX_CNT_L, 8'h01);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h99);
    lag(p);
    chk("restart lag", 32'(t1), 32'(p));
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h00);
    $display("t_presc done");
  endtask
  task automatic t_dual();
    int ho;
    int hc;
    int d0;
    apb(1'b1, tpc_pkg::IDX_RLD_L, 8'h0a);
    apb(1'b1, tpc_pkg::IDX_CMP_H, 8'h00);
    apb(1'b1, tpc_pkg::IDX_CMP_L, 8'h04);
    apb(1'b1, tpc_pkg::IDX_CTL0, 8'h80);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h80);
    hi(ho, hc);
    d0 = 6 - ho;
    chk("duty", 32'h2, 32'(ho - hc));
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h00);
    apb(1'b1, tpc_pkg::IDX_CTL0, 8'h86);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h80);
    hi(ho, hc);
    chk("deadband", 32'h3, 32'(6 - ho - d0));
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h40);
    wait_clk(4);
    chk("idle pol1", 32'h2, {30'h0, out, comp});
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'hc0);
    hi(ho, hc);
    chk("inverse duty", 32'h2, 32'(hc - ho));
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h00);
    apb(1'b1, tpc_pkg::IDX_CTL0, 8'h00);
    // Single PWM: high from match at four to reload at ten
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h83);
    hi(ho, hc);
    chk("single duty", 32'h6, 32'(ho));
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h00);
    $display("t_dual done");
  endtask
  task automatic t_pol();
    apb(1'b1, tpc_pkg::IDX_RLD_H, 8'h01);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h01);
    alt_fn <= 1'b1;
    wait_clk(4);
    chk("pad pol0", 32'h0, {31'h0, pad});
    // Polarity is set while stopped, then the timer starts
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h41);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'hc1);
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h81);
    wait_clk(4);
    chk("pol while run", 32'h1, {31'h0, out});
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h01);
    alt_fn <= 1'b0;
    wait_clk(4);
    chk("stop level", 32'h1, {30'h0, out, pad});
    $display("t_pol done");
  endtask
  task automatic t_cap();
    logic [15:0] v;
    apb(1'b1, tpc_pkg::IDX_RLD_L, 8'hff);
    apb(1'b1, tpc_pkg::IDX_RLD_H, 8'hff);
    apb(1'b1, tpc_pkg::IDX_CTL0, 8'h80);
    for (int p = 0; p < 2; p++) begin
      level <= (p == 1);
      apb(1'b1, tpc_pkg::IDX_CTL1, 8'h01 | 8'(p << 6));
      apb(1'b1, tpc_pkg::IDX_CMP_L, 8'h00);
      apb(1'b1, tpc_pkg::IDX_CMP_H, 8'h00);
      apb(1'b1, tpc_pkg::IDX_CTL1, 8'h81 | 8'(p << 6));
      for (int k = 0; k < 2; k++) begin
        level <= (p != k);
        wait_clk(4);
        apb(1'b0, tpc_pkg::IDX_CMP_H, 8'h00);
        v[15:8] = q[7:0];
        apb(1'b0, tpc_pkg::IDX_CMP_L, 8'h00);
        v[7:0] = q[7:0];
        chk("capture", 32'(k), 32'(v > 8 && v < 60));
      end
    end
    apb(1'b1, tpc_pkg::IDX_CTL1, 8'h00);
    $display("t_cap done");
  endtask

  initial begin
    wait_clk(12);
    arst_n_i <= 1'b1;
    t_regs();
    t_presc();
    t_dual();
    t_pol();
    t_cap();
    wrap_up();
  end
endmodule
